// File: vie_pkg.sv
// Shared types and constants of the virtualization instruction error encoder.
package vie_pkg;

  localparam int FIELD_W_DEF = 32;

  typedef logic [4:0] vie_code_t;

  localparam vie_code_t ERR_NONE          = 5'h00;
  localparam vie_code_t ERR_CALL_ROOT     = 5'h01;
  localparam vie_code_t ERR_CLR_ADDR      = 5'h02;
  localparam vie_code_t ERR_CLR_ENPTR     = 5'h03;
  localparam vie_code_t ERR_LAUNCH_CLEAR  = 5'h04;
  localparam vie_code_t ERR_RESUME_LAUNCH = 5'h05;
  localparam vie_code_t ERR_RESUME_CORRUPT = 5'h06;
  localparam vie_code_t ERR_ENTRY_CTRL    = 5'h07;
  localparam vie_code_t ERR_ENTRY_HOST    = 5'h08;
  localparam vie_code_t ERR_LOAD_ADDR     = 5'h09;
  localparam vie_code_t ERR_LOAD_ENPTR    = 5'h0A;
  localparam vie_code_t ERR_LOAD_REV      = 5'h0B;
  localparam vie_code_t ERR_FIELD_UNSUP   = 5'h0C;
  localparam vie_code_t ERR_FIELD_RO      = 5'h0D;
  localparam vie_code_t ERR_ENABLE_ROOT   = 5'h0F;
  localparam vie_code_t ERR_EXEC_PTR      = 5'h10;
  localparam vie_code_t ERR_EXEC_LAUNCH   = 5'h11;
  localparam vie_code_t ERR_EXEC_MISMATCH = 5'h12;
  localparam vie_code_t ERR_CALL_CLEAR    = 5'h13;
  localparam vie_code_t ERR_CALL_EXITCTL  = 5'h14;
  localparam vie_code_t ERR_CALL_MONREV   = 5'h16;
  localparam vie_code_t ERR_DISABLE_DUAL  = 5'h17;
  localparam vie_code_t ERR_CALL_FEATURES = 5'h18;
  localparam vie_code_t ERR_MGMT_EXEC_CTRL = 5'h19;
  localparam vie_code_t ERR_ENTRY_SS      = 5'h1A;

  typedef enum logic [3:0] {
    VIE_OP_NONE        = 4'h0,
    VIE_OP_HYPERCALL   = 4'h1,
    VIE_OP_CLEAR       = 4'h2,
    VIE_OP_LAUNCH      = 4'h3,
    VIE_OP_RESUME      = 4'h4,
    VIE_OP_PTR_LOAD    = 4'h5,
    VIE_OP_FIELD_READ  = 4'h6,
    VIE_OP_FIELD_WRITE = 4'h7,
    VIE_OP_ENABLE      = 4'h8,
    VIE_OP_DISABLE     = 4'h9
  } vie_op_t;

  typedef struct packed {
    logic in_root;
    logic dual_active;
    logic activate_dual;
    logic deactivate_dual;
    logic mgmt_return;
  } vie_mode_t;

  typedef struct packed {
    logic addr_bad;
    logic is_enable_ptr;
    logic not_clear;
    logic not_launched;
    logic corrupted;
    logic rev_bad;
    logic unsupported;
    logic read_only;
    logic ctrl_bad;
    logic host_bad;
    logic exec_ptr_bad;
    logic exec_not_launched;
    logic exec_ptr_mismatch;
    logic exit_ctrl_bad;
    logic features_bad;
    logic ss_blocked;
  } vie_fail_t;

  typedef struct packed {
    vie_op_t   op;
    vie_mode_t mode;
    vie_fail_t fail;
  } vie_req_t;

  typedef struct packed {
    logic      hit;
    vie_code_t code;
  } vie_verdict_t;

  typedef enum logic [1:0] {
    VIE_ST_IDLE = 2'b00,
    VIE_ST_EVAL = 2'b01
  } vie_state_t;

  localparam vie_verdict_t VERDICT_PASS = '{hit: 1'b0, code: ERR_NONE};

endpackage

// File: vie_instr_check.sv
// Per-instruction failure checks that precede any entry checks.
`timescale 1ns/1ps
module vie_instr_check (
  // Captured request.
  input  vie_pkg::vie_req_t     req,
  // Verdict and entry permission.
  output vie_pkg::vie_verdict_t verdict,
  output logic                  entry_go
);

  always_comb begin
    verdict  = vie_pkg::VERDICT_PASS;
    entry_go = 1'b0;
    unique case (req.op)
      vie_pkg::VIE_OP_HYPERCALL: begin
        if (req.mode.activate_dual) begin
          if (req.fail.not_clear) begin
            verdict = '{1'b1, vie_pkg::ERR_CALL_CLEAR};
          end else if (req.fail.exit_ctrl_bad) begin
            verdict = '{1'b1, vie_pkg::ERR_CALL_EXITCTL};
          end else if (req.fail.rev_bad) begin
            verdict = '{1'b1, vie_pkg::ERR_CALL_MONREV};
          end else if (req.fail.features_bad) begin
            verdict = '{1'b1, vie_pkg::ERR_CALL_FEATURES};
          end
        end else if (req.mode.in_root) begin
          verdict = '{1'b1, vie_pkg::ERR_CALL_ROOT};
        end
      end
      vie_pkg::VIE_OP_CLEAR: begin
        if (req.fail.addr_bad) begin
          verdict = '{1'b1, vie_pkg::ERR_CLR_ADDR};
        end else if (req.fail.is_enable_ptr) begin
          verdict = '{1'b1, vie_pkg::ERR_CLR_ENPTR};
        end
      end
      vie_pkg::VIE_OP_LAUNCH: begin
        if (req.fail.not_clear) begin
          verdict = '{1'b1, vie_pkg::ERR_LAUNCH_CLEAR};
        end else begin
          entry_go = 1'b1;
        end
      end
      vie_pkg::VIE_OP_RESUME: begin
        if (req.fail.not_launched) begin
          verdict = '{1'b1, vie_pkg::ERR_RESUME_LAUNCH};
        end else if (req.fail.corrupted) begin
          verdict = '{1'b1, vie_pkg::ERR_RESUME_CORRUPT};
        end else begin
          entry_go = 1'b1;
        end
      end
      vie_pkg::VIE_OP_PTR_LOAD: begin
        if (req.fail.addr_bad) begin
          verdict = '{1'b1, vie_pkg::ERR_LOAD_ADDR};
        end else if (req.fail.is_enable_ptr) begin
          verdict = '{1'b1, vie_pkg::ERR_LOAD_ENPTR};
        end else if (req.fail.rev_bad) begin
          verdict = '{1'b1, vie_pkg::ERR_LOAD_REV};
        end
      end
      vie_pkg::VIE_OP_FIELD_READ: begin
        if (req.fail.unsupported) begin
          verdict = '{1'b1, vie_pkg::ERR_FIELD_UNSUP};
        end
      end
      vie_pkg::VIE_OP_FIELD_WRITE: begin
        if (req.fail.unsupported) begin
          verdict = '{1'b1, vie_pkg::ERR_FIELD_UNSUP};
        end else if (req.fail.read_only) begin
          verdict = '{1'b1, vie_pkg::ERR_FIELD_RO};
        end
      end
      vie_pkg::VIE_OP_ENABLE: begin
        if (req.mode.in_root) begin
          verdict = '{1'b1, vie_pkg::ERR_ENABLE_ROOT};
        end
      end
      vie_pkg::VIE_OP_DISABLE: begin
        if (req.mode.dual_active) begin
          verdict = '{1'b1, vie_pkg::ERR_DISABLE_DUAL};
        end
      end
      default: begin
        verdict = vie_pkg::VERDICT_PASS;
      end
    endcase
  end

endmodule

// File: vie_entry_check.sv
// Entry checks on stack-segment blocking, executive structure, control and host-state fields.
`timescale 1ns/1ps
module vie_entry_check (
  // Captured conditions.
  input  vie_pkg::vie_mode_t    mode,
  input  vie_pkg::vie_fail_t    fail,
  // Verdict.
  output vie_pkg::vie_verdict_t verdict
);

  // A fixed priority picks one failing cause; other causes may also be present.
  always_comb begin
    verdict = vie_pkg::VERDICT_PASS;
    if (fail.ss_blocked) begin
      verdict = '{1'b1, vie_pkg::ERR_ENTRY_SS};
    end else if (fail.exec_ptr_bad) begin
      verdict = '{1'b1, vie_pkg::ERR_EXEC_PTR};
    end else if (fail.exec_not_launched) begin
      verdict = '{1'b1, vie_pkg::ERR_EXEC_LAUNCH};
    end else if (mode.deactivate_dual && fail.exec_ptr_mismatch) begin
      verdict = '{1'b1, vie_pkg::ERR_EXEC_MISMATCH};
    end else if (fail.ctrl_bad && mode.mgmt_return) begin
      verdict = '{1'b1, vie_pkg::ERR_MGMT_EXEC_CTRL};
    end else if (fail.ctrl_bad) begin
      verdict = '{1'b1, vie_pkg::ERR_ENTRY_CTRL};
    end else if (fail.host_bad) begin
      verdict = '{1'b1, vie_pkg::ERR_ENTRY_HOST};
    end
  end

endmodule

// File: vie_encoder.sv
// Top of the virtualization instruction error encoder.
`timescale 1ns/1ps
module vie_encoder #(
  parameter int FIELD_W = vie_pkg::FIELD_W_DEF
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Request from the instruction pipeline.
  input  wire logic             req_valid,
  input  vie_pkg::vie_req_t     req,
  output logic                  req_ready,
  // Result.
  output logic [FIELD_W-1:0]    err_field,
  output logic                  err_done,
  output logic                  err_fail
);

  typedef struct packed {
    vie_pkg::vie_state_t st;
    vie_pkg::vie_req_t   req;
    logic [FIELD_W-1:0]  field;
    logic                done;
    logic                fail;
    logic                ready;
  } vie_regs_t;

  localparam logic [FIELD_W-1:0] FIELD_RST = '0;

  vie_regs_t             s_r;
  vie_regs_t             s_nxt;
  vie_pkg::vie_verdict_t instr_v;
  vie_pkg::vie_verdict_t entry_v;
  logic                  entry_go;

  function automatic logic [FIELD_W-1:0] vie_widen(input vie_pkg::vie_code_t c);
    return FIELD_W'(c);
  endfunction

  vie_instr_check u_instr (
    .req      (s_r.req),
    .verdict  (instr_v),
    .entry_go (entry_go)
  );

  vie_entry_check u_entry (
    .mode    (s_r.req.mode),
    .fail    (s_r.req.fail),
    .verdict (entry_v)
  );

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.fail = 1'b0;
    unique case (s_r.st)
      vie_pkg::VIE_ST_IDLE: begin
        if (req_valid) begin
          s_nxt.req   = req;
          s_nxt.st    = vie_pkg::VIE_ST_EVAL;
          s_nxt.ready = 1'b0;
        end
      end
      vie_pkg::VIE_ST_EVAL: begin
        s_nxt.st    = vie_pkg::VIE_ST_IDLE;
        s_nxt.ready = 1'b1;
        s_nxt.done  = 1'b1;
        if (instr_v.hit) begin
          s_nxt.fail  = 1'b1;
          s_nxt.field = vie_widen(instr_v.code);
        end else if (entry_go && entry_v.hit) begin
          s_nxt.fail  = 1'b1;
          s_nxt.field = vie_widen(entry_v.code);
        end
      end
      default: begin
        s_nxt.st    = vie_pkg::VIE_ST_IDLE;
        s_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r.st    <= vie_pkg::VIE_ST_IDLE;
      s_r.req   <= '0;
      s_r.field <= FIELD_RST;
      s_r.done  <= 1'b0;
      s_r.fail  <= 1'b0;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready = s_r.ready;
  assign err_field = s_r.field;
  assign err_done  = s_r.done;
  assign err_fail  = s_r.fail;

  // Request classes from which the code assertions start.
  logic acc;
  logic hyper_act;
  logic entry_req;
  logic entry_deep;

  assign acc = req_valid && s_r.ready;
  assign hyper_act = acc && req.op == vie_pkg::VIE_OP_HYPERCALL && req.mode.activate_dual;
  assign entry_req = acc
                     && ((req.op == vie_pkg::VIE_OP_LAUNCH && !req.fail.not_clear)
                     || (req.op == vie_pkg::VIE_OP_RESUME && !req.fail.not_launched
                     && !req.fail.corrupted));
  assign entry_deep = entry_req && !req.fail.ss_blocked && !req.fail.exec_ptr_bad
                      && !req.fail.exec_not_launched
                      && !(req.mode.deactivate_dual && req.fail.exec_ptr_mismatch);

  default clocking vie_cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_hyper_root: assert property (
    acc && req.op == vie_pkg::VIE_OP_HYPERCALL && req.mode.in_root && !req.mode.activate_dual
    |-> ##2 err_done && err_fail && err_field == vie_widen(vie_pkg::ERR_CALL_ROOT))
    else $error("Hypercall in root operation did not report its code.");

  a_hyper_clear: assert property (
    hyper_act && req.fail.not_clear
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_CALL_CLEAR))
    else $error("Activating hypercall on a non-clear structure did not report its code.");

  a_hyper_exit: assert property (
    hyper_act && !req.fail.not_clear && req.fail.exit_ctrl_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_CALL_EXITCTL))
    else $error("Activating hypercall with bad exit controls did not report its code.");

  a_hyper_monrev: assert property (
    hyper_act && !req.fail.not_clear && !req.fail.exit_ctrl_bad && req.fail.rev_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_CALL_MONREV))
    else $error("Activating hypercall with a wrong monitor revision did not report its code.");

  a_hyper_feat: assert property (
    hyper_act && !req.fail.not_clear && !req.fail.exit_ctrl_bad && !req.fail.rev_bad
    && req.fail.features_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_CALL_FEATURES))
    else $error("Activating hypercall with bad monitor features did not report its code.");

  a_clear_codes: assert property (
    acc && req.op == vie_pkg::VIE_OP_CLEAR && (req.fail.addr_bad || req.fail.is_enable_ptr)
    |-> ##2 err_fail && err_field == vie_widen($past(req.fail.addr_bad, 2)
        ? vie_pkg::ERR_CLR_ADDR : vie_pkg::ERR_CLR_ENPTR))
    else $error("Structure clear failure reported a wrong code.");

  a_launch_clear: assert property (
    acc && req.op == vie_pkg::VIE_OP_LAUNCH && req.fail.not_clear
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_LAUNCH_CLEAR))
    else $error("Launch of a non-clear structure did not report its code.");

  a_resume_state: assert property (
    acc && req.op == vie_pkg::VIE_OP_RESUME && req.fail.not_launched
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_RESUME_LAUNCH))
    else $error("Resume of an unlaunched structure did not report its code.");

  a_resume_corrupt: assert property (
    acc && req.op == vie_pkg::VIE_OP_RESUME && !req.fail.not_launched && req.fail.corrupted
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_RESUME_CORRUPT))
    else $error("Resume of a corrupted structure did not report its code.");

  a_entry_ctrl: assert property (
    entry_deep && req.fail.ctrl_bad && !req.mode.mgmt_return
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_ENTRY_CTRL))
    else $error("Entry with bad control fields did not report its code.");

  a_entry_host: assert property (
    entry_deep && !req.fail.ctrl_bad && req.fail.host_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_ENTRY_HOST))
    else $error("Entry with bad host-state fields did not report its code.");

  a_ptr_addr: assert property (
    acc && req.op == vie_pkg::VIE_OP_PTR_LOAD && req.fail.addr_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_LOAD_ADDR))
    else $error("Pointer load with a bad address did not report its code.");

  a_ptr_enptr: assert property (
    acc && req.op == vie_pkg::VIE_OP_PTR_LOAD && !req.fail.addr_bad && req.fail.is_enable_ptr
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_LOAD_ENPTR))
    else $error("Pointer load of the enable-region pointer did not report its code.");

  a_ptr_load: assert property (
    acc && req.op == vie_pkg::VIE_OP_PTR_LOAD && !req.fail.addr_bad
    && !req.fail.is_enable_ptr && req.fail.rev_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_LOAD_REV))
    else $error("Pointer load with wrong revision did not report its code.");

  a_field_unsup: assert property (
    acc && (req.op == vie_pkg::VIE_OP_FIELD_READ || req.op == vie_pkg::VIE_OP_FIELD_WRITE)
    && req.fail.unsupported
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_FIELD_UNSUP))
    else $error("Access to an unsupported component did not report its code.");

  a_field_ro: assert property (
    acc && req.op == vie_pkg::VIE_OP_FIELD_WRITE && !req.fail.unsupported && req.fail.read_only
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_FIELD_RO))
    else $error("Write to a read-only component did not report its code.");

  a_enable_root: assert property (
    acc && req.op == vie_pkg::VIE_OP_ENABLE && req.mode.in_root
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_ENABLE_ROOT))
    else $error("Enable in root operation did not report its code.");

  a_disable_dual: assert property (
    acc && req.op == vie_pkg::VIE_OP_DISABLE && req.mode.dual_active
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_DISABLE_DUAL))
    else $error("Disable under dual-monitor handling did not report its code.");

  a_exec_ptr: assert property (
    entry_req && !req.fail.ss_blocked && req.fail.exec_ptr_bad
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_EXEC_PTR))
    else $error("Entry with a bad executive pointer did not report its code.");

  a_exec_launch: assert property (
    entry_req && !req.fail.ss_blocked && !req.fail.exec_ptr_bad && req.fail.exec_not_launched
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_EXEC_LAUNCH))
    else $error("Entry with an unlaunched executive structure did not report its code.");

  a_exec_mismatch: assert property (
    entry_req && !req.fail.ss_blocked && !req.fail.exec_ptr_bad && !req.fail.exec_not_launched
    && req.mode.deactivate_dual && req.fail.exec_ptr_mismatch
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_EXEC_MISMATCH))
    else $error("Deactivating entry with a foreign executive pointer did not report its code.");

  a_mgmt_ctrl: assert property (
    entry_deep && req.fail.ctrl_bad && req.mode.mgmt_return
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_MGMT_EXEC_CTRL))
    else $error("Return-from-management entry with bad controls did not report its code.");

  a_ss_blocked: assert property (
    entry_req && req.fail.ss_blocked
    |-> ##2 err_fail && err_field == vie_widen(vie_pkg::ERR_ENTRY_SS))
    else $error("Entry blocked by a stack-segment load did not report its code.");

  a_mgmt_no_seven: assert property (
    err_done && err_fail && s_r.req.mode.mgmt_return
    |-> err_field != vie_widen(vie_pkg::ERR_ENTRY_CTRL))
    else $error("Return-from-management entry reported the plain control code.");

  a_spare_codes: assert property (
    err_fail |-> err_field != FIELD_W'(14) && err_field != FIELD_W'(21))
    else $error("An unassigned error code was produced.");

  a_field_hold: assert property (
    $changed(err_field) |-> err_done && err_fail)
    else $error("Error field changed without a reported failure.");

  a_pass_hold: assert property (
    err_done && !err_fail |-> $stable(err_field))
    else $error("Error field changed on a request without a failure.");

  a_fail_done: assert property (
    err_fail |-> err_done)
    else $error("Failure flag rose without the done pulse.");

  a_done_pulse: assert property (
    err_done |=> !err_done)
    else $error("Done pulse stood for more than one cycle.");

  a_ready_idle: assert property (
    !req_ready |=> req_ready)
    else $error("Ready stayed low for more than the evaluation cycle.");

  a_busy_ignore: assert property (
    req_valid && !req_ready |=> $stable(s_r.req))
    else $error("A request presented while busy was taken.");

  a_answer_time: assert property (
    acc |=> !req_ready && !err_done ##1 req_ready && err_done ##1 !err_done)
    else $error("Result did not follow an accepted request after one evaluation cycle.");

  c_hyper_root: cover property (
    acc && req.op == vie_pkg::VIE_OP_HYPERCALL && req.mode.in_root ##2 err_fail);
  c_entry_fail: cover property (
    acc && req.op == vie_pkg::VIE_OP_RESUME ##2 err_fail
    && err_field == vie_widen(vie_pkg::ERR_ENTRY_HOST));
  c_mgmt_return: cover property (
    err_fail && err_field == vie_widen(vie_pkg::ERR_MGMT_EXEC_CTRL));
  c_clean_pass: cover property (acc ##2 err_done && !err_fail);
  c_refused: cover property (req_valid && !req_ready ##1 err_done);

endmodule

// File: vie_encoder_tb_top.sv
// Self-checking testbench of the virtualization instruction error encoder.
`timescale 1ns/1ps
module vie_encoder_tb_top;
  typedef struct packed {
    logic              hit;
    vie_pkg::vie_code_t code;
    logic [31:0]       field;
  } vie_note_t;

  logic              core_clk;
  logic              nrst;
  logic              req_valid;
  vie_pkg::vie_req_t req;
  logic              req_ready;
  logic [31:0]       err_field;
  logic              err_done;
  logic              err_fail;
  vie_note_t         notes[$];
  vie_note_t         n;
  logic [31:0]       exp_field;
  int                err_count;
  int                n_checks;
  int                seed;

  vie_encoder #(.FIELD_W(32)) i_dut (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .err_field (err_field),
    .err_done  (err_done),
    .err_fail  (err_fail)
  );

  always #4 core_clk = ~core_clk;

  function automatic vie_pkg::vie_code_t entry_code(vie_pkg::vie_mode_t m, vie_pkg::vie_fail_t f);
    if (f.ss_blocked) return vie_pkg::ERR_ENTRY_SS;
    if (f.exec_ptr_bad) return vie_pkg::ERR_EXEC_PTR;
    if (f.exec_not_launched) return vie_pkg::ERR_EXEC_LAUNCH;
    if (m.deactivate_dual && f.exec_ptr_mismatch) return vie_pkg::ERR_EXEC_MISMATCH;
    if (f.ctrl_bad) return m.mgmt_return ? vie_pkg::ERR_MGMT_EXEC_CTRL : vie_pkg::ERR_ENTRY_CTRL;
    if (f.host_bad) return vie_pkg::ERR_ENTRY_HOST;
    return vie_pkg::ERR_NONE;
  endfunction

  function automatic vie_pkg::vie_code_t exp_code(vie_pkg::vie_req_t r);
    vie_pkg::vie_fail_t f;
    f = r.fail;
    case (r.op)
      vie_pkg::VIE_OP_HYPERCALL: begin
        if (!r.mode.activate_dual) return r.mode.in_root ? 5'h01 : 5'h00;
        if (f.not_clear) return 5'h13;
        if (f.exit_ctrl_bad) return 5'h14;
        if (f.rev_bad) return 5'h16;
        return f.features_bad ? 5'h18 : 5'h00;
      end
      vie_pkg::VIE_OP_CLEAR: return f.addr_bad ? 5'h02 : (f.is_enable_ptr ? 5'h03 : 5'h00);
      vie_pkg::VIE_OP_LAUNCH: return f.not_clear ? 5'h04 : entry_code(r.mode, f);
      vie_pkg::VIE_OP_RESUME: begin
        if (f.not_launched) return 5'h05;
        return f.corrupted ? 5'h06 : entry_code(r.mode, f);
      end
      vie_pkg::VIE_OP_PTR_LOAD: begin
        if (f.addr_bad) return 5'h09;
        return f.is_enable_ptr ? 5'h0A : (f.rev_bad ? 5'h0B : 5'h00);
      end
      vie_pkg::VIE_OP_FIELD_READ: return f.unsupported ? 5'h0C : 5'h00;
      vie_pkg::VIE_OP_FIELD_WRITE: return f.unsupported ? 5'h0C : (f.read_only ? 5'h0D : 5'h00);
      vie_pkg::VIE_OP_ENABLE: return r.mode.in_root ? 5'h0F : 5'h00;
      vie_pkg::VIE_OP_DISABLE: return r.mode.dual_active ? 5'h17 : 5'h00;
      default: return 5'h00;
    endcase
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_field(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Waits at falling edges until the block accepts a request.
  task automatic wait_ready;
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 50) begin
      err_count++;
      summarize();
    end
  endtask

  // Presents one request; a probe keeps a failing request up while the block is busy.
  task automatic send(input vie_pkg::vie_req_t r, input logic probe);
    vie_pkg::vie_code_t c;
    c = exp_code(r);
    @(negedge core_clk);
    wait_ready();
    req_valid = 1'b1;
    req = r;
    if (c != 5'h00) exp_field = {27'h0000000, c};
    notes.push_back('{hit: (c != 5'h00), code: c, field: exp_field});
    @(negedge core_clk);
    chk_bit(err_done, 1'b0);
    chk_bit(req_ready, 1'b0);
    if (probe) begin
      req.op = vie_pkg::VIE_OP_CLEAR;
      req.fail = 16'hFFFF;
    end else begin
      req_valid = 1'b0;
    end
    @(negedge core_clk);
    chk_bit(err_done, 1'b1);
    chk_bit(req_ready, 1'b1);
    req_valid = 1'b0;
  endtask

  // Takes the oldest note whenever a result appears.
  always @(negedge core_clk) begin
    if (nrst === 1'b1 && err_done === 1'b1) begin
      if (notes.size() == 0) begin
        chk_bit(1'b1, 1'b0);
      end else begin
        n = notes.pop_front();
        chk_bit(err_fail, n.hit);
        chk_bit(err_field == 32'h0000000E || err_field == 32'h00000015, 1'b0);
        case (n.code)
          5'h01: chk_field(err_field, n.field);
          5'h02, 5'h03: chk_field(err_field, n.field);
          5'h04: chk_field(err_field, n.field);
          5'h05: chk_field(err_field, n.field);
          5'h06: chk_field(err_field, n.field);
          5'h07, 5'h08: chk_field(err_field, n.field);
          5'h09, 5'h0A, 5'h0B: chk_field(err_field, n.field);
          5'h0C, 5'h0D: chk_field(err_field, n.field);
          5'h0F: chk_field(err_field, n.field);
          5'h10, 5'h11: chk_field(err_field, n.field);
          5'h12: chk_field(err_field, n.field);
          5'h13, 5'h14: chk_field(err_field, n.field);
          5'h16, 5'h18: chk_field(err_field, n.field);
          5'h17: chk_field(err_field, n.field);
          5'h19: chk_field(err_field, n.field);
          5'h1A: chk_field(err_field, n.field);
          default: chk_field(err_field, n.field);
        endcase
      end
    end
  end

  initial begin
    vie_pkg::vie_req_t r;
    core_clk = 1'b0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    exp_field = 32'h00000000;
    err_count = 0;
    n_checks = 0;
    seed = 32'hA981;
    repeat (20) @(negedge core_clk);
    chk_field(err_field, 32'h00000000);
    chk_bit(req_ready, 1'b1);
    nrst = 1'b1;
    // Every operation against every mode and each single failing condition.
    for (int op = 0; op < 10; op++) begin
      for (int b = -1; b < 16; b++) begin
        for (int m = 0; m < 32; m++) begin
          r.op = vie_pkg::vie_op_t'(op[3:0]);
          r.mode = m[4:0];
          r.fail = (b < 0) ? 16'h0000 : (16'h0001 << b);
          send(r, (m == 3));
        end
      end
    end
    // Reset in mid-run clears the field.
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_field(err_field, 32'h00000000);
    chk_bit(err_done, 1'b0);
    nrst = 1'b1;
    exp_field = 32'h00000000;
    // Several failing conditions at once exercise the priorities.
    for (int i = 0; i < 1500; i++) begin
      r.op = vie_pkg::vie_op_t'(4'($unsigned($random(seed)) % 10));
      r.mode = 5'($random(seed));
      r.fail = 16'($random(seed) & $random(seed) & $random(seed));
      send(r, i[0]);
    end
    repeat (4) @(negedge core_clk);
    chk_bit(notes.size() == 0, 1'b1);
    summarize();
  end
endmodule
